//--- pkg/rtia_pkg.sv
// constants, field layout and helpers of the rtc indirect access port
// assumes one system clock; the timebase arrives as a pin and is sampled
package rtia_pkg;

   // special function register offsets and reset values
   localparam logic [7:0] ADR_OFFSET = 8'hac;
   localparam logic [7:0] DAT_OFFSET = 8'had;
   localparam logic [7:0] ADR_RESET = 8'h00;
   localparam logic [7:0] DAT_RESET = 8'h00;

   // address/control field positions
   localparam int ADR_BUSY_BIT = 7;
   localparam int ADR_AUTO_READ_BIT = 6;
   localparam int ADR_UNUSED_BIT = 5;
   localparam int ADR_SHORT_BIT = 4;
   localparam int ADR_ADDR_MSB = 3;

   // internal register map
   localparam logic [3:0] IA_CAPTURE0 = 4'h0;
   localparam logic [3:0] IA_CAPTURE3 = 4'h3;
   localparam logic [3:0] IA_CONTROL = 4'h4;
   localparam logic [3:0] IA_OSC_CTRL = 4'h5;
   localparam logic [3:0] IA_OSC_CFG = 4'h6;
   localparam logic [3:0] IA_ALARM0 = 4'h8;
   localparam logic [3:0] IA_ALARM3 = 4'hb;

   // clock control register fields
   localparam int CTL_POWER_BIT = 7;
   localparam int CTL_MISSING_CLK_BIT = 6;
   localparam int CTL_OSC_FAIL_BIT = 5;
   localparam int CTL_RUN_BIT = 4;
   localparam int CTL_SET_BIT = 1;
   localparam int CTL_CAPTURE_BIT = 0;
   localparam logic [7:0] CTL_RESET = 8'h00;

   // oscillator control register fields
   localparam int OSC_GAIN_BIT = 7;
   localparam int OSC_XTAL_MODE_BIT = 6;
   localparam int OSC_BIAS_X2_BIT = 5;
   localparam int OSC_CLK_VALID_BIT = 4;
   localparam int OSC_LOW_FREQ_BIT = 3;
   localparam logic [7:0] OSC_CTRL_RESET = 8'h00;

   // oscillator configuration register fields
   localparam int CFG_LOAD_READY_BIT = 6;
   localparam int CFG_LOAD_CAP_MSB = 3;
   localparam logic [7:0] OSC_CFG_RESET = 8'h00;

   // positions in the status pin synchroniser
   localparam int SYNC_CLK_VALID = 0;
   localparam int SYNC_LOAD_READY = 1;
   localparam int SYNC_OSC_FAIL = 2;
   localparam int SYNC_TICK = 3;
   localparam int SYNC_WIDTH = 4;

   // access strobe lengths in system clock cycles
   localparam logic [3:0] STROBE_NORMAL_CYCLES = 4'h7;
   localparam logic [3:0] STROBE_SHORT_CYCLES = 4'h6;

   // timer step per timebase tick
   localparam logic [31:0] TIMER_INC_NORMAL = 32'h0000_0001;
   localparam logic [31:0] TIMER_INC_LOW_FREQ = 32'h0000_0002;

   // nominal timebase frequencies in hz, tolerance in percent
   localparam int XTAL_FREQ_HZ = 32768;
   localparam int SELF_OSC_MIN_HZ = 10000;
   localparam int SELF_OSC_MAX_HZ = 40000;
   localparam int SELF_OSC_LOW_BIAS_HZ = 20000;
   localparam int SELF_OSC_HIGH_BIAS_HZ = 40000;
   localparam int LOW_FREQ_NOM_HZ = 16400;
   localparam int LOW_FREQ_TOL_PCT = 20;

   // software waits in ms around oscillator start
   localparam int XTAL_START_WAIT_MS = 20;
   localparam int SETTLE_WAIT_MS = 2;

   typedef enum logic [1:0] {
      SRC_SELF_OSC = 2'b00,
      SRC_CRYSTAL = 2'b01,
      SRC_LOW_FREQ = 2'b10
   } rtia_src_e;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_XFER = 1'b1
   } rtia_state_e;

   // capture and alarm bytes step the address after each transfer
   function automatic logic rtiaIsAutoInc(input logic [3:0] a);
      return (a <= IA_CAPTURE3) || ((a >= IA_ALARM0) && (a <= IA_ALARM3));
   endfunction : rtiaIsAutoInc

   function automatic logic rtiaIsMapped(input logic [3:0] a);
      return (a <= IA_ALARM3) && (a != 4'h7);
   endfunction : rtiaIsMapped

   // bits that hardware owns are never stored from a write
   function automatic logic [7:0] rtiaWriteMask(input logic [3:0] a);
      logic [7:0] m;
      m = 8'hff;
      if (a == IA_CONTROL) begin
         m[CTL_OSC_FAIL_BIT] = 1'b0;
         m[CTL_SET_BIT] = 1'b0;
         m[CTL_CAPTURE_BIT] = 1'b0;
      end else if (a == IA_OSC_CTRL) begin
         m[OSC_CLK_VALID_BIT] = 1'b0;
      end else if (a == IA_OSC_CFG) begin
         m[CFG_LOAD_READY_BIT] = 1'b0;
      end
      return m;
   endfunction : rtiaWriteMask

endpackage : rtia_pkg

//--- design/rtia_pin_sync.sv
// three-stage synchroniser with agreement filter and rise pulse
// assumes pins change asynchronously to clock
module rtia_pin_sync
   import rtia_pkg::*;
#(
   parameter int WIDTH = SYNC_WIDTH
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // pins
   input wire logic [WIDTH-1:0] pinIn,
   // synchronised view
   output logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rise
);
   logic [WIDTH-1:0] s1_ff, s2_ff, s3_ff, stable_ff, rise_ff;
   logic [WIDTH-1:0] nxt_stable, nxt_rise;

   // a change counts once stages two and three agree
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         nxt_stable[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : stable_ff[i];
      end
      nxt_rise = nxt_stable & ~stable_ff;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         stable_ff <= '0;
         rise_ff <= '0;
      end else begin
         s1_ff <= pinIn;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         stable_ff <= nxt_stable;
         rise_ff <= nxt_rise;
      end
   end

   assign level = stable_ff;
   assign rise = rise_ff;

   chk_sync_agree_only: assert property (@(posedge clock) disable iff (!rst_n) // [RULE28]
      ((stable_ff ^ $past(stable_ff)) & ($past(s2_ff) ^ $past(s3_ff))) == '0)
      else $error("synchronised level moved without stage agreement");

endmodule : rtia_pin_sync

//--- design/rtia_indirect_port.sv
// indirect access port and timebase control of the real-time clock
// assumes a processor on the special function register bus and oscillator pins
// Function
// RULE1 - bit 7 shows busy; writing 1 starts an indirect read
// RULE2 - bit 6 enables automatic read
// RULE3 - bit 5 reads zero, writes ignored
// RULE4 - bit 4 selects short access strobe
// RULE5 - bits 3:0 select the internal register target
// RULE6 - capture and alarm accesses increment the address afterwards
// RULE7 - data register holds last byte moved to or from target
// RULE8 - software uses plain loads and stores on the data register
// RULE9 - clock counts its own timebase, crossed into system clock
// RULE10 - timebase from cmos clock, low frequency oscillator, or oscillator
// RULE11 - crystal 32.768 khz; self oscillation 10 to 40 khz
// RULE12 - low frequency oscillator nominal 16.4 khz, twenty percent
// RULE13 - crystal start: mode, gain off bias on, load cap, power
// RULE14 - wait 20 ms, poll clock valid, then load ready
// RULE15 - then gain on bias off, detector on, wait, clear wake flags
// RULE16 - with cmos clock, check fail flag 2 ms after power
// RULE17 - cmos clock wants lowest bias and gain control off
// RULE18 - self oscillation when mode cleared; bias picks 20 or 40 khz
// RULE19 - self oscillation starts at once; load cap trims frequency
// RULE20 - low frequency enable both enables and selects that oscillator
// RULE21 - low frequency ticks add two to the 32-bit timer
// RULE22 - bias and load cap settings shift low frequency oscillator
// RULE23 - writing data register starts an indirect write
// RULE24 - transfer takes 7 cycles, or 6 with short strobe
// RULE25 - with automatic read, each data read starts the next read
// RULE26 - map: capture 0-3, control 4, osc 5, config 6, alarm 8-b
// RULE27 - busy clears only at transfer end; accesses while busy ignored
// RULE28 - timebase and status cross domains through synchronisers
module rtia_indirect_port
   import rtia_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // special function register bus
   input wire logic [7:0] sfrAddr,
   input wire logic sfrWrite,
   input wire logic sfrRead,
   input wire logic [7:0] sfrWdata,
   output logic [7:0] sfrRdata,
   // oscillator controls
   output logic oscPowerEnable,
   output logic crystalModeSelect,
   output logic gainControlEnable,
   output logic biasDoublingEnable,
   output logic lowFreqOscEnable,
   output logic missingClockEnable,
   output logic [3:0] loadCapSetting,
   output rtia_src_e timebaseSource,
   // oscillator status pins
   input wire logic timebaseTick,
   input wire logic clockValidFlag,
   input wire logic loadCapReadyFlag,
   input wire logic oscillatorFailFlag,
   // observation
   output logic busy,
   output logic [31:0] timerValue
);
   logic adrWrite, datWrite, datRead, xferShortNow;
   logic startRead, startWrite, startAny, xferDone, capturePulse, setPulse;
   logic [SYNC_WIDTH-1:0] syncLevel, syncRise;
   logic [7:0] intRead, nxt_rdata, rdata_ff;
   rtia_state_e state_ff, nxt_state;
   logic [3:0] cnt_ff, nxt_cnt, addr_ff, nxt_addr;
   logic isRead_ff, nxt_isRead, autoRead_ff, nxt_autoRead, short_ff, nxt_short;
   logic [7:0] dat_ff, nxt_dat;
   logic [7:0] regFile_ff [0:15];
   logic [7:0] nxt_regFile [0:15];
   logic [31:0] timer_ff, nxt_timer;

   // timebase and status pins into the system clock
   rtia_pin_sync #(
      .WIDTH(SYNC_WIDTH)
   ) u_pin_sync (
      .clock(clock),
      .rst_n(rst_n),
      .pinIn({timebaseTick, oscillatorFailFlag, loadCapReadyFlag, clockValidFlag}),
      .level(syncLevel),
      .rise(syncRise)
   ); // [RULE9] [RULE28]

   // bus decode
   assign adrWrite = sfrWrite && (sfrAddr == ADR_OFFSET);
   assign datWrite = sfrWrite && (sfrAddr == DAT_OFFSET);
   assign datRead = sfrRead && (sfrAddr == DAT_OFFSET);
   assign busy = (state_ff == ST_XFER); // [RULE1]
   assign xferShortNow = adrWrite ? sfrWdata[ADR_SHORT_BIT] : short_ff; // [RULE4]
   assign startRead = !busy && ((adrWrite && sfrWdata[ADR_BUSY_BIT]) || (datRead && autoRead_ff)); // [RULE1] [RULE25]
   assign startWrite = !busy && datWrite; // [RULE23]
   assign startAny = startRead || startWrite;
   assign xferDone = busy && (cnt_ff == 4'h0);
   assign capturePulse = xferDone && !isRead_ff && (addr_ff == IA_CONTROL) && dat_ff[CTL_CAPTURE_BIT];
   assign setPulse = xferDone && !isRead_ff && (addr_ff == IA_CONTROL) && dat_ff[CTL_SET_BIT];

   // internal read view with live status bits
   always_comb begin
      intRead = 8'h00;
      case (addr_ff) // [RULE26]
         IA_CONTROL: begin
            intRead = regFile_ff[IA_CONTROL];
            intRead[CTL_OSC_FAIL_BIT] = syncLevel[SYNC_OSC_FAIL]; // [RULE16]
         end
         IA_OSC_CTRL: begin
            intRead = regFile_ff[IA_OSC_CTRL];
            intRead[OSC_CLK_VALID_BIT] = syncLevel[SYNC_CLK_VALID];
         end
         IA_OSC_CFG: begin
            intRead = regFile_ff[IA_OSC_CFG];
            intRead[CFG_LOAD_READY_BIT] = syncLevel[SYNC_LOAD_READY];
         end
         default: begin
            intRead = rtiaIsMapped(addr_ff) ? regFile_ff[addr_ff] : 8'h00;
         end
      endcase
   end

   // access port sequencing
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_isRead = isRead_ff;
      nxt_autoRead = autoRead_ff;
      nxt_short = short_ff;
      nxt_addr = addr_ff;
      nxt_dat = dat_ff;
      if (!busy) begin
         if (adrWrite) begin
            nxt_autoRead = sfrWdata[ADR_AUTO_READ_BIT]; // [RULE2]
            nxt_short = sfrWdata[ADR_SHORT_BIT]; // [RULE4]
            nxt_addr = sfrWdata[ADR_ADDR_MSB:0]; // [RULE5]
         end
         if (datWrite) begin
            nxt_dat = sfrWdata; // [RULE7]
         end
         if (startAny) begin
            nxt_state = ST_XFER;
            nxt_isRead = startRead;
            nxt_cnt = xferShortNow ? 4'(STROBE_SHORT_CYCLES - 4'h1) : 4'(STROBE_NORMAL_CYCLES - 4'h1); // [RULE24]
         end
      end else if (xferDone) begin
         nxt_state = ST_IDLE; // [RULE27]
         if (isRead_ff) begin
            nxt_dat = intRead; // [RULE7]
         end
         if (rtiaIsAutoInc(addr_ff)) begin
            nxt_addr = 4'(addr_ff + 4'h1); // [RULE6]
         end
      end else begin
         nxt_cnt = 4'(cnt_ff - 4'h1);
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_ff <= ST_IDLE;
         cnt_ff <= 4'h0;
         isRead_ff <= 1'b0;
         autoRead_ff <= ADR_RESET[ADR_AUTO_READ_BIT];
         short_ff <= ADR_RESET[ADR_SHORT_BIT];
         addr_ff <= ADR_RESET[ADR_ADDR_MSB:0];
         dat_ff <= DAT_RESET;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         isRead_ff <= nxt_isRead;
         autoRead_ff <= nxt_autoRead;
         short_ff <= nxt_short;
         addr_ff <= nxt_addr;
         dat_ff <= nxt_dat;
      end
   end

   // internal register file
   always_comb begin
      nxt_regFile = regFile_ff;
      if (xferDone && !isRead_ff && rtiaIsMapped(addr_ff)) begin
         nxt_regFile[addr_ff] = dat_ff & rtiaWriteMask(addr_ff); // [RULE23]
      end
      if (capturePulse) begin
         for (int i = 0; i < 4; i++) begin
            nxt_regFile[4'(i)] = timer_ff[8*i +: 8];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         for (int i = 0; i < 16; i++) begin
            regFile_ff[i] <= 8'h00;
         end
         regFile_ff[IA_CONTROL] <= CTL_RESET;
         regFile_ff[IA_OSC_CTRL] <= OSC_CTRL_RESET;
         regFile_ff[IA_OSC_CFG] <= OSC_CFG_RESET;
      end else begin
         regFile_ff <= nxt_regFile;
      end
   end

   // 32-bit timer on the synchronised timebase
   always_comb begin
      nxt_timer = timer_ff;
      if (setPulse) begin
         nxt_timer = {regFile_ff[3], regFile_ff[2], regFile_ff[1], regFile_ff[0]};
      end else if (regFile_ff[IA_CONTROL][CTL_RUN_BIT] && syncRise[SYNC_TICK]) begin // [RULE9]
         nxt_timer = timer_ff + (lowFreqOscEnable ? TIMER_INC_LOW_FREQ : TIMER_INC_NORMAL); // [RULE21]
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         timer_ff <= 32'h0000_0000;
      end else begin
         timer_ff <= nxt_timer;
      end
   end

   // register read data, one cycle after the address
   always_comb begin
      nxt_rdata = 8'h00;
      if (sfrAddr == ADR_OFFSET) begin
         nxt_rdata = {busy, autoRead_ff, 1'b0, short_ff, addr_ff}; // [RULE1] [RULE3]
      end else if (sfrAddr == DAT_OFFSET) begin
         nxt_rdata = dat_ff;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rdata_ff <= 8'h00;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign sfrRdata = rdata_ff;
   assign timerValue = timer_ff;

   // oscillator controls from the internal registers
   assign oscPowerEnable = regFile_ff[IA_CONTROL][CTL_POWER_BIT];
   assign missingClockEnable = regFile_ff[IA_CONTROL][CTL_MISSING_CLK_BIT];
   assign gainControlEnable = regFile_ff[IA_OSC_CTRL][OSC_GAIN_BIT];
   assign crystalModeSelect = regFile_ff[IA_OSC_CTRL][OSC_XTAL_MODE_BIT]; // [RULE11] [RULE18]
   assign biasDoublingEnable = regFile_ff[IA_OSC_CTRL][OSC_BIAS_X2_BIT]; // [RULE18] [RULE22]
   assign lowFreqOscEnable = regFile_ff[IA_OSC_CTRL][OSC_LOW_FREQ_BIT]; // [RULE12] [RULE20]
   assign loadCapSetting = regFile_ff[IA_OSC_CFG][CFG_LOAD_CAP_MSB:0]; // [RULE19] [RULE22]

   // timebase source; low frequency enable overrides the oscillator
   always_comb begin
      if (lowFreqOscEnable) begin
         timebaseSource = SRC_LOW_FREQ; // [RULE20]
      end else if (crystalModeSelect) begin
         timebaseSource = SRC_CRYSTAL; // [RULE10]
      end else begin
         timebaseSource = SRC_SELF_OSC; // [RULE10] [RULE19]
      end
   end

   // checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   sequence sXferNormal;
      busy [*7] ##1 !busy;
   endsequence

   sequence sXferShort;
      busy [*6] ##1 !busy;
   endsequence

   chk_busy_normal_len: assert property ( // [RULE24]
      startAny && !xferShortNow |=> sXferNormal)
      else $error("normal strobe transfer not 7 cycles");

   chk_busy_short_len: assert property ( // [RULE4]
      startAny && xferShortNow |=> sXferShort)
      else $error("short strobe transfer not 6 cycles");

   chk_busy_bit_read: assert property ( // [RULE1]
      busy && (sfrAddr == ADR_OFFSET) |=> sfrRdata[ADR_BUSY_BIT])
      else $error("busy bit not reported while transferring");

   chk_unused_reads_zero: assert property ( // [RULE3]
      adrWrite && !busy ##1 (sfrAddr == ADR_OFFSET) |=> !sfrRdata[ADR_UNUSED_BIT])
      else $error("unused address bit read as one");

   chk_addr_auto_inc: assert property ( // [RULE6]
      xferDone && rtiaIsAutoInc(addr_ff) |=> addr_ff == 4'($past(addr_ff) + 4'h1))
      else $error("address did not step after capture or alarm access");

   chk_addr_holds: assert property ( // [RULE5]
      xferDone && !rtiaIsAutoInc(addr_ff) |=> $stable(addr_ff))
      else $error("address moved after a plain register access");

   chk_read_lands_data: assert property ( // [RULE7]
      xferDone && isRead_ff |=> dat_ff == $past(intRead))
      else $error("read transfer did not load the data register");

   chk_auto_read_start: assert property ( // [RULE25]
      !busy && datRead && autoRead_ff |=> busy [*6])
      else $error("automatic read did not start a transfer");

   chk_no_auto_read: assert property ( // [RULE2]
      !busy && datRead && !autoRead_ff |=> !busy)
      else $error("data read started a transfer with automatic read off");

   chk_busy_ignores: assert property ( // [RULE27]
      busy && !xferDone && sfrWrite |=> $stable(dat_ff) && $stable(addr_ff) && busy)
      else $error("access while busy disturbed the transfer");

   chk_write_lands_alarm: assert property ( // [RULE23]
      xferDone && !isRead_ff && (addr_ff == IA_ALARM0) |=> regFile_ff[IA_ALARM0] == $past(dat_ff))
      else $error("write transfer did not reach the alarm byte");

   chk_timer_double: assert property ( // [RULE21]
      !setPulse && regFile_ff[IA_CONTROL][CTL_RUN_BIT] && syncRise[SYNC_TICK] && lowFreqOscEnable
      |=> timer_ff == $past(timer_ff) + TIMER_INC_LOW_FREQ)
      else $error("low frequency tick did not add two");

   chk_source_select: assert property ( // [RULE20]
      lowFreqOscEnable |-> timebaseSource == SRC_LOW_FREQ)
      else $error("low frequency enable did not select the timebase");

endmodule : rtia_indirect_port

//--- tb/rtia_osc_model.sv
// behavioural oscillator and status pins facing the indirect access port
// assumes the bench enables ticking; ticks stand still while not running
module rtia_osc_model #(
   parameter int START_CYCLES = 16
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // bench control
   input wire logic tickEn,
   // oscillator controls
   input wire logic oscPowerEnable,
   input wire logic crystalModeSelect,
   input wire logic lowFreqOscEnable,
   input wire logic missingClockEnable,
   // status pins
   output logic timebaseTick,
   output logic clockValidFlag,
   output logic loadCapReadyFlag,
   output logic oscillatorFailFlag
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] div_ff;
   logic [7:0] upCnt_ff;
   logic running;
   logic started;
   // low freq source and powered oscillator start at once
   assign running = tickEn && (lowFreqOscEnable || oscPowerEnable);
   assign started = upCnt_ff == 8'(START_CYCLES);
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         div_ff <= 5'h00;
         upCnt_ff <= 8'h00;
      end else begin
         div_ff <= running ? div_ff + 5'h01 : 5'h00;
         upCnt_ff <= !oscPowerEnable ? 8'h00 : (started ? upCnt_ff : upCnt_ff + 8'h01);
      end
   end
   assign timebaseTick = div_ff[4];
   // valid and load ready only after the power start delay; valid also needs crystal mode
   assign clockValidFlag = crystalModeSelect && started;
   assign loadCapReadyFlag = started;
   // fail flag when the detector sees no clock
   assign oscillatorFailFlag = missingClockEnable && !running;
endmodule : rtia_osc_model

//--- tb/rtia_indirect_port_bench.sv
// self-checking bench of the indirect access port
// assumes the oscillator model drives the status pins
`define CHK(nm, e, g) check(nm, 32'(e), 32'(g))
module rtia_indirect_port_bench import rtia_pkg::*; ();
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic sfrWrite = 1'b0;
   logic sfrRead = 1'b0;
   logic tickEn = 1'b0;
   logic [7:0] sfrAddr = 8'h00;
   logic [7:0] sfrWdata = 8'h00;
   logic [7:0] sfrRdata, d, r;
   logic [7:0] al [4];
   logic oscPowerEnable, crystalModeSelect, gainControlEnable, biasDoublingEnable;
   logic lowFreqOscEnable, missingClockEnable, timebaseTick, clockValidFlag;
   logic loadCapReadyFlag, oscillatorFailFlag, busy, prevTick, s;
   logic [3:0] loadCapSetting;
   logic [31:0] timerValue, t0;
   rtia_src_e timebaseSource;
   int seed = 32'h556e;
   int n_fail = 0;
   int n_tests = 0;
   int cyc = 0;
   int riseCnt = 0;
   int n, r0;

   rtia_indirect_port rtia_indirect_port_inst (.clock(clock), .rst_n(rst_n), .sfrAddr(sfrAddr),
      .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
      .oscPowerEnable(oscPowerEnable), .crystalModeSelect(crystalModeSelect),
      .gainControlEnable(gainControlEnable), .biasDoublingEnable(biasDoublingEnable),
      .lowFreqOscEnable(lowFreqOscEnable), .missingClockEnable(missingClockEnable),
      .loadCapSetting(loadCapSetting), .timebaseSource(timebaseSource), .timebaseTick(timebaseTick),
      .clockValidFlag(clockValidFlag), .loadCapReadyFlag(loadCapReadyFlag),
      .oscillatorFailFlag(oscillatorFailFlag), .busy(busy), .timerValue(timerValue));

   rtia_osc_model rtia_osc_model_inst (.clock(clock), .rst_n(rst_n), .tickEn(tickEn),
      .oscPowerEnable(oscPowerEnable), .crystalModeSelect(crystalModeSelect),
      .lowFreqOscEnable(lowFreqOscEnable), .missingClockEnable(missingClockEnable),
      .timebaseTick(timebaseTick), .clockValidFlag(clockValidFlag),
      .loadCapReadyFlag(loadCapReadyFlag), .oscillatorFailFlag(oscillatorFailFlag));

   initial begin
      forever #2 clock = ~clock;
   end

   // counts timebase rises seen by the bench
   always @(posedge clock) begin
      prevTick <= timebaseTick;
      if (timebaseTick === 1'b1 && prevTick === 1'b0) riseCnt <= riseCnt + 1;
   end

   task end_sim();
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_sim

   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         end_sim();
      end
   end

   task check(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : check

   task wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge clock);
      sfrAddr = a;
      sfrWdata = v;
      sfrWrite = 1'b1;
      @(negedge clock);
      sfrWrite = 1'b0;
   endtask : wr

   task rd(input logic [7:0] a, input logic st, output logic [7:0] v);
      @(negedge clock);
      sfrAddr = a;
      sfrRead = st;
      @(negedge clock);
      sfrRead = 1'b0;
      v = sfrRdata;
   endtask : rd

   task idle(output int c);
      c = 0;
      while (busy === 1'b1 && c < 50) begin
         c++;
         @(negedge clock);
      end
   endtask : idle

   function automatic logic [1:0] expSrc(input logic [7:0] v);
      return v[3] ? 2'b10 : (v[6] ? 2'b01 : 2'b00);
   endfunction : expSrc

   initial begin
      repeat (6) @(negedge clock);
      rst_n = 1'b1;
      rd(ADR_OFFSET, 1'b0, r);
      `CHK("adr reset", ADR_RESET, r);
      rd(DAT_OFFSET, 1'b0, r);
      `CHK("dat reset", DAT_RESET, r);
      rd(8'hae, 1'b0, r);
      `CHK("unmapped", 8'h00, r);
      wr(ADR_OFFSET, 8'h65);
      rd(ADR_OFFSET, 1'b0, r);
      `CHK("adr fields", 8'h45, r);
      for (int i = 0; i < 4; i++) begin
         s = i[0];
         d = (i == 0) ? 8'h48 : 8'($random(seed));
         wr(ADR_OFFSET, {3'b000, s, IA_OSC_CTRL});
         wr(DAT_OFFSET, d);
         idle(n);
         `CHK("write cycles", s ? STROBE_SHORT_CYCLES : STROBE_NORMAL_CYCLES, n);
         `CHK("osc gain mode", d[7:6], {gainControlEnable, crystalModeSelect});
         `CHK("osc bias lfo", {d[5], d[3]}, {biasDoublingEnable, lowFreqOscEnable});
         `CHK("source", expSrc(d), timebaseSource);
         wr(ADR_OFFSET, {1'b1, 2'b00, s, IA_OSC_CTRL});
         idle(n);
         `CHK("read cycles", s ? STROBE_SHORT_CYCLES : STROBE_NORMAL_CYCLES, n);
         rd(DAT_OFFSET, 1'b1, r);
         `CHK("read back", d & 8'hef, r);
         `CHK("no autoread", 1'b0, busy);
      end
      wr(ADR_OFFSET, 8'h18);
      for (int k = 0; k < 4; k++) begin
         al[k] = 8'($random(seed));
         wr(DAT_OFFSET, al[k]);
         wr(DAT_OFFSET, ~al[k]);
         rd(ADR_OFFSET, 1'b0, r);
         `CHK("busy bit", 8'h98 + k, r);
         idle(n);
      end
      rd(ADR_OFFSET, 1'b0, r);
      `CHK("address step", 8'h1c, r);
      wr(ADR_OFFSET, 8'hc8);
      idle(n);
      for (int k = 0; k < 4; k++) begin
         rd(DAT_OFFSET, 1'b1, r);
         `CHK("alarm byte", al[k], r);
         idle(n);
      end
      rd(ADR_OFFSET, 1'b0, r);
      `CHK("autoread end", 8'h4c, r);
      for (int m = 0; m < 2; m++) begin
         wr(ADR_OFFSET, {4'h0, IA_OSC_CTRL});
         wr(DAT_OFFSET, m ? 8'h60 : 8'h08);
         idle(n);
         wr(ADR_OFFSET, {4'h0, IA_OSC_CFG});
         wr(DAT_OFFSET, 8'h05);
         idle(n);
         wr(ADR_OFFSET, {4'h0, IA_CONTROL});
         wr(DAT_OFFSET, m ? 8'h90 : 8'h10);
         idle(n);
         t0 = timerValue;
         r0 = riseCnt;
         tickEn = 1'b1;
         repeat (300 + m * 64) @(negedge clock);
         tickEn = 1'b0;
         repeat (20) @(negedge clock);
         `CHK("timer step", (m ? 1 : 2) * (riseCnt - r0), timerValue - t0);
      end
      wr(ADR_OFFSET, {4'h8, IA_OSC_CTRL});
      idle(n);
      rd(DAT_OFFSET, 1'b0, r);
      `CHK("clock valid", 8'h70, r);
      wr(ADR_OFFSET, {4'h8, IA_OSC_CFG});
      idle(n);
      rd(DAT_OFFSET, 1'b0, r);
      `CHK("load ready", 8'h45, r);
      `CHK("load cap", 4'h5, loadCapSetting);
      wr(ADR_OFFSET, {4'h0, IA_OSC_CTRL});
      wr(DAT_OFFSET, 8'hc0);
      idle(n);
      wr(ADR_OFFSET, {4'h0, IA_CONTROL});
      wr(DAT_OFFSET, 8'hd0);
      idle(n);
      `CHK("gain bias", 2'b10, {gainControlEnable, biasDoublingEnable});
      `CHK("power detect", 2'b11, {oscPowerEnable, missingClockEnable});
      wr(ADR_OFFSET, {4'h8, IA_CONTROL});
      idle(n);
      rd(DAT_OFFSET, 1'b0, r);
      `CHK("fail flag", 8'hf0, r);
      wr(ADR_OFFSET, {4'h0, IA_OSC_CTRL});
      wr(DAT_OFFSET, 8'h40);
      idle(n);
      `CHK("cmos bias", 2'b00, {gainControlEnable, biasDoublingEnable});
      tickEn = 1'b1;
      wr(ADR_OFFSET, {4'h8, IA_CONTROL});
      idle(n);
      rd(DAT_OFFSET, 1'b0, r);
      `CHK("clock present", 8'hd0, r);
      tickEn = 1'b0;
      end_sim();
   end
endmodule : rtia_indirect_port_bench
